// ==== hw/rsr_pkg.sv ====
package rsr_pkg;

    // Register addresses on the host register port.
    localparam logic [4:0] ADDR_AUX_SYNTH = 5'h17;
    localparam logic [4:0] ADDR_CONV_CTRL = 5'h18;
    localparam logic [4:0] ADDR_CONV_READ = 5'h19;
    localparam logic [4:0] ADDR_RXLEN_HI = 5'h1a;
    localparam logic [4:0] ADDR_RXLEN_LO = 5'h1b;

    // Field positions of the auxiliary synthesizer word.
    localparam int AUX_BIAS4X_BIT = 23;
    localparam int AUX_VCO_DIRECT_BIT = 22;
    localparam int AUX_EXT_RF_BIT = 21;
    localparam int AUX_PRESC_EN_BIT = 20;
    localparam int AUX_B_LSB = 10;
    localparam int AUX_A_LSB = 0;
    localparam int PRESC_LOW_SHIFT = 5;

    // Field positions of the first receive-length register.
    localparam int RXL_SKIP_CRC_BIT = 7;
    localparam int RXL_DIRECT_BIT = 6;
    localparam logic [7:0] RXL_HI_MASK = 8'hc3;

    // Reset values.
    localparam logic [23:0] AUX_SYNTH_RST = 24'h011846;
    localparam logic [7:0] CONV_CTRL_RST = 8'h00;
    localparam logic [7:0] CONV_READ_RST = 8'h00;
    localparam logic [7:0] RXLEN_RST = 8'h00;

    // Host direct command that starts a conversion.
    localparam logic [7:0] CMD_TRIGGER_ADC = 8'h87;

    // Converter input selection codes.
    localparam logic [2:0] MSEL_MIXER_I = 3'h0;
    localparam logic [2:0] MSEL_MIXER_Q = 3'h1;
    localparam logic [2:0] MSEL_EXT_PIN = 3'h2;

    // Timing: one microsecond tick, then a count of ticks.
    localparam int CLK_FREQ_MHZ = 100;
    localparam int ADC_VALID_TIME_US = 20;
    localparam int TICK_CYCLES = CLK_FREQ_MHZ;
    localparam int ADC_VALID_TICKS = ADC_VALID_TIME_US;

    typedef struct packed {
        logic bias4x;
        logic vco_direct;
        logic ext_rf;
        logic presc_en;
        logic [9:0] b_value;
        logic [9:0] a_value;
    } rsr_synth_t;

    typedef struct packed {
        logic rx_start;
        logic rx_end;
        logic header;
        logic second_byte;
        logic err3;
        logic finished;
    } rsr_rx_evt_t;

    function automatic logic [16:0] rsr_div_ratio(input logic [9:0] b, input logic [9:0] a);
        logic [16:0] bw;
        logic [16:0] aw;
        bw = {7'h00, b};
        aw = {7'h00, a};
        rsr_div_ratio = (bw << PRESC_LOW_SHIFT) + (aw << PRESC_LOW_SHIFT) + aw;
    endfunction

endpackage

// ==== hw/rsr_adc_seq.sv ====
`timescale 1ns/100ps
module rsr_adc_seq
    import rsr_pkg::*;
(
    // Clock and clear
    input wire logic mclk,
    input wire logic clear,
    // Control
    input wire logic start,
    input wire logic [2:0] msel,
    // Sampled levels
    input wire logic [7:0] mixer_i,
    input wire logic [7:0] mixer_q,
    input wire logic [7:0] ext_pin,
    // Result
    output logic [7:0] result,
    output logic busy
);

    typedef enum logic [1:0] {ADC_IDLE = 2'b01, ADC_CONV = 2'b10} rsr_adc_state_t;

    rsr_adc_state_t state_r, state_nxt;
    logic [6:0] div_r, div_nxt;
    logic [4:0] ticks_r, ticks_nxt;
    logic [7:0] result_r, result_nxt;
    logic [7:0] sample;
    logic tick;

    always_comb
    begin
        if (msel == MSEL_MIXER_Q)
            sample = mixer_q;
        else if (msel == MSEL_EXT_PIN)
            sample = ext_pin;
        else
            sample = mixer_i; // see RQ8
        tick = (div_r == 7'(TICK_CYCLES - 1));
        state_nxt = state_r;
        div_nxt = div_r;
        ticks_nxt = ticks_r;
        result_nxt = result_r;
        case (state_r)
            ADC_IDLE:
            begin
                if (start)
                begin
                    state_nxt = ADC_CONV;
                    div_nxt = 7'h00;
                    ticks_nxt = 5'h00;
                end
            end
            ADC_CONV:
            begin
                // A new trigger during a conversion restarts the timing.
                div_nxt = tick ? 7'h00 : div_r + 7'h01;
                if (start)
                begin
                    div_nxt = 7'h00;
                    ticks_nxt = 5'h00;
                end
                else if (tick && ticks_r == 5'(ADC_VALID_TICKS - 1))
                begin
                    state_nxt = ADC_IDLE;
                    result_nxt = sample; // see RQ9
                end
                else if (tick)
                    ticks_nxt = ticks_r + 5'h01;
            end
            default:
                state_nxt = ADC_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
        begin
            state_r <= ADC_IDLE;
            div_r <= 7'h00;
            ticks_r <= 5'h00;
            result_r <= CONV_READ_RST;
        end
        else
        begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            ticks_r <= ticks_nxt;
            result_r <= result_nxt;
        end
    end

    assign result = result_r;
    assign busy = (state_r == ADC_CONV);

endmodule

// ==== hw/rsr_rx_opts.sv ====
`timescale 1ns/100ps
module rsr_rx_opts
    import rsr_pkg::*;
(
    // Clock and clear
    input wire logic mclk,
    input wire logic clear,
    // Options from the length registers
    input wire logic skip_crc_opt,
    input wire logic direct_opt,
    // Receiver events and bytes
    input wire rsr_rx_evt_t evt,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_is_crc,
    // Results
    output logic crc_check_en,
    output logic fifo_push,
    output logic [7:0] fifo_byte,
    output logic irq_header_line,
    output logic third_error_irq_line
);

    logic skip_r, skip_nxt;
    logic push_r, push_nxt;
    logic [7:0] byte_r, byte_nxt;

    always_comb
    begin
        skip_nxt = skip_r;
        // The option is captured once per frame so a clear at frame end cannot cut it short.
        if (evt.rx_start)
            skip_nxt = skip_crc_opt; // see RQ10
        else if (evt.rx_end)
            skip_nxt = 1'b0;
        push_nxt = byte_valid && (!byte_is_crc || skip_r); // see RQ11
        byte_nxt = byte_valid ? byte_data : byte_r;
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
        begin
            skip_r <= 1'b0;
            push_r <= 1'b0;
            byte_r <= 8'h00;
        end
        else
        begin
            skip_r <= skip_nxt;
            push_r <= push_nxt;
            byte_r <= byte_nxt;
        end
    end

    assign crc_check_en = !skip_r; // see RQ10
    assign fifo_push = push_r;
    assign fifo_byte = byte_r;
    assign irq_header_line = direct_opt ? evt.second_byte : evt.header; // see RQ12
    assign third_error_irq_line = direct_opt ? evt.finished : evt.err3; // see RQ13

endmodule

// ==== hw/rsr_regs.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: Aux word holds B high, A low.
// RQ2: Bit 21 picks external RF source.
// RQ3: Bit 22 picks direct oscillator path.
// RQ4: Bit 20 enables divider and prescaler.
// RQ5: Bit 23 quadruples amplifier bias.
// RQ6: Aux word presets to 01 18 46.
// RQ7: Converter control byte, clears to zero.
// RQ8: Select field picks converter input source.
// RQ9: Command 87 gives result within 20us.
// RQ10: Skip-CRC bit applies to next reception only.
// RQ11: Skipped-CRC reception forwards CRC bytes too.
// RQ12: Direct option swaps header for second-byte.
// RQ13: Direct option swaps error3 for finished.
// RQ14: Ten-bit length split across two registers.
// RQ15: Length registers clear at reset, disable, end; a host write in the frame-end cycle is kept instead.
// RQ16: Host issues trigger command to measure.
// RQ17: Readout register ignores host writes.
// RQ18: Aux word moves as three bytes, MSB first.
module rsr_regs
    import rsr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Chip enable pin, low disables and clears
    input wire logic chip_en,
    // Host register port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Host direct commands
    input wire logic host_cmd_valid,
    input wire logic [7:0] host_cmd,
    // Converter inputs
    input wire logic [2:0] msel,
    input wire logic [7:0] mixer_i_level,
    input wire logic [7:0] mixer_q_level,
    input wire logic [7:0] ext_pin_level,
    // Synthesizer and converter controls
    output rsr_synth_t aux_synth,
    output logic [16:0] aux_div_ratio,
    output logic [7:0] dac_value,
    output logic adc_busy,
    // Receiver side
    input wire rsr_rx_evt_t rx_evt,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_is_crc,
    output logic [9:0] rx_len,
    output logic crc_check_en,
    output logic fifo_push,
    output logic [7:0] fifo_byte,
    output logic irq_header_line,
    output logic third_error_irq_line
);

    // Chip enable synchroniser.
    logic en_meta_r, en_meta_nxt;
    logic en_sync_r, en_sync_nxt;
    logic clear;

    always_comb
    begin
        en_meta_nxt = chip_en;
        en_sync_nxt = en_meta_r;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            en_meta_r <= 1'b0;
            en_sync_r <= 1'b0;
        end
        else
        begin
            en_meta_r <= en_meta_nxt;
            en_sync_r <= en_sync_nxt;
        end
    end

    // Power-on reset and chip disable both return every register to its preset.
    assign clear = !reset_n || !en_sync_r; // see RQ15

    // One-hot register select: aux, control, readout, length high, length low.
    function automatic logic [4:0] reg_hit(input logic [4:0] a);
        logic [4:0] h;
        h = 5'h00;
        if (a == ADDR_AUX_SYNTH)
            h = 5'h01;
        else if (a == ADDR_CONV_CTRL)
            h = 5'h02;
        else if (a == ADDR_CONV_READ)
            h = 5'h04;
        else if (a == ADDR_RXLEN_HI)
            h = 5'h08;
        else if (a == ADDR_RXLEN_LO)
            h = 5'h10;
        return h;
    endfunction

    // Access decode, shared by the write strobes and the read mux.
    logic [4:0] hit;
    logic wr_aux, wr_dac, wr_rxhi, wr_rxlo, rd_aux;

    assign hit = reg_hit(host_addr);

    always_comb
    begin
        wr_aux = 1'b0;
        wr_dac = 1'b0;
        wr_rxhi = 1'b0;
        wr_rxlo = 1'b0;
        rd_aux = 1'b0;
        if (hit[0])
        begin
            wr_aux = host_wr;
            rd_aux = host_rd && !host_wr;
        end
        else if (hit[1])
            wr_dac = host_wr;
        else if (hit[3])
            wr_rxhi = host_wr;
        else if (hit[4])
            wr_rxlo = host_wr;
        // Writes to the readout register and to unmapped addresses fall through.
    end

    // Auxiliary synthesizer word, staged byte by byte.
    logic [23:0] aux_r, aux_nxt;
    logic [15:0] stage_r, stage_nxt;
    logic [1:0] idx_r, idx_nxt;

    always_comb
    begin
        aux_nxt = aux_r;
        stage_nxt = stage_r;
        idx_nxt = idx_r;
        // Each select frame starts again at the most significant byte.
        if (!host_sel)
            idx_nxt = 2'h0; // see RQ18
        else if (wr_aux || rd_aux)
            idx_nxt = (idx_r == 2'h2) ? 2'h0 : idx_r + 2'h1;
        if (wr_aux)
        begin
            if (idx_r == 2'h0)
                stage_nxt[15:8] = host_wdata;
            else if (idx_r == 2'h1)
                stage_nxt[7:0] = host_wdata;
            else
                aux_nxt = {stage_r, host_wdata}; // see RQ18
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
        begin
            aux_r <= AUX_SYNTH_RST; // see RQ6
            stage_r <= 16'h0000;
            idx_r <= 2'h0;
        end
        else
        begin
            aux_r <= aux_nxt;
            stage_r <= stage_nxt;
            idx_r <= idx_nxt;
        end
    end

    // Aux field outputs.
    always_comb
    begin
        aux_synth.bias4x = aux_r[AUX_BIAS4X_BIT]; // see RQ5
        aux_synth.vco_direct = aux_r[AUX_VCO_DIRECT_BIT]; // see RQ3
        aux_synth.ext_rf = aux_r[AUX_EXT_RF_BIT]; // see RQ2
        aux_synth.presc_en = aux_r[AUX_PRESC_EN_BIT]; // see RQ4
        aux_synth.b_value = aux_r[AUX_B_LSB +: 10]; // see RQ1
        aux_synth.a_value = aux_r[AUX_A_LSB +: 10]; // see RQ1
    end

    // Ratio is loaded with the aux word so the loop logic need not multiply.
    localparam logic [16:0] RATIO_RST = rsr_div_ratio(AUX_SYNTH_RST[AUX_B_LSB +: 10],
        AUX_SYNTH_RST[AUX_A_LSB +: 10]);
    logic [16:0] ratio_r, ratio_nxt;

    always_comb
    begin
        ratio_nxt = rsr_div_ratio(aux_nxt[AUX_B_LSB +: 10], aux_nxt[AUX_A_LSB +: 10]); // see RQ1
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
            ratio_r <= RATIO_RST; // see RQ6
        else
            ratio_r <= ratio_nxt;
    end

    assign aux_div_ratio = ratio_r;

    // Converter control value.
    logic [7:0] dac_r, dac_nxt;

    always_comb
    begin
        dac_nxt = wr_dac ? host_wdata : dac_r; // see RQ7
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
            dac_r <= CONV_CTRL_RST; // see RQ7
        else
            dac_r <= dac_nxt;
    end

    assign dac_value = dac_r;

    // Converter sequencing, started only by the trigger command.
    logic adc_start;
    logic [7:0] adc_result;

    assign adc_start = host_cmd_valid && (host_cmd == CMD_TRIGGER_ADC); // see RQ9 RQ16

    rsr_adc_seq u_adc
    (
        .mclk(mclk),
        .clear(clear),
        .start(adc_start),
        .msel(msel),
        .mixer_i(mixer_i_level),
        .mixer_q(mixer_q_level),
        .ext_pin(ext_pin_level),
        .result(adc_result),
        .busy(adc_busy)
    );

    // Receive length registers.
    logic [7:0] rxhi_r, rxhi_nxt;
    logic [7:0] rxlo_r, rxlo_nxt;

    always_comb
    begin
        rxhi_nxt = rxhi_r;
        rxlo_nxt = rxlo_r;
        if (rx_evt.rx_end)
        begin
            rxhi_nxt = RXLEN_RST; // see RQ15
            rxlo_nxt = RXLEN_RST; // see RQ15
        end
        // A host write in the same cycle as frame end is kept rather than lost.
        if (wr_rxhi)
            rxhi_nxt = host_wdata & RXL_HI_MASK; // see RQ14
        if (wr_rxlo)
            rxlo_nxt = host_wdata; // see RQ14
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
        begin
            rxhi_r <= RXLEN_RST;
            rxlo_r <= RXLEN_RST;
        end
        else
        begin
            rxhi_r <= rxhi_nxt;
            rxlo_r <= rxlo_nxt;
        end
    end

    assign rx_len = {rxhi_r[1:0], rxlo_r}; // see RQ14

    rsr_rx_opts u_rx
    (
        .mclk(mclk),
        .clear(clear),
        .skip_crc_opt(rxhi_r[RXL_SKIP_CRC_BIT]),
        .direct_opt(rxhi_r[RXL_DIRECT_BIT]),
        .evt(rx_evt),
        .byte_valid(rx_byte_valid),
        .byte_data(rx_byte),
        .byte_is_crc(rx_byte_is_crc),
        .crc_check_en(crc_check_en),
        .fifo_push(fifo_push),
        .fifo_byte(fifo_byte),
        .irq_header_line(irq_header_line),
        .third_error_irq_line(third_error_irq_line)
    );

    // Read path, one cycle after the strobe.
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    always_comb
    begin
        rdata_nxt = rdata_r;
        rvalid_nxt = host_rd;
        if (host_rd)
        begin
            if (hit[0])
            begin
                if (idx_r == 2'h0)
                    rdata_nxt = aux_r[23:16]; // see RQ18
                else if (idx_r == 2'h1)
                    rdata_nxt = aux_r[15:8];
                else
                    rdata_nxt = aux_r[7:0];
            end
            else if (hit[1])
                rdata_nxt = dac_r;
            else if (hit[2])
                rdata_nxt = adc_result; // see RQ17
            else if (hit[3])
                rdata_nxt = rxhi_r;
            else if (hit[4])
                rdata_nxt = rxlo_r;
            else
                rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clear)
        begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign host_rdata = rdata_r;
    assign host_rvalid = rvalid_r;

endmodule

// ==== bench/rsr_regs_properties.sv ====
`timescale 1ns/100ps
module rsr_regs_props
    import rsr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic chip_en,
    // Host port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    input wire logic host_cmd_valid,
    input wire logic [7:0] host_cmd,
    // Controls
    input wire rsr_synth_t aux_synth,
    input wire logic [16:0] aux_div_ratio,
    input wire logic [7:0] dac_value,
    input wire logic adc_busy,
    // Receiver
    input wire rsr_rx_evt_t rx_evt,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_is_crc,
    input wire logic [9:0] rx_len,
    input wire logic crc_check_en,
    input wire logic fifo_push,
    input wire logic [7:0] fifo_byte
);
    default clocking cb @(posedge mclk);
    endclocking
    // The enable pin is synchronised inside, so checks pause while it is low.
    default disable iff (!reset_n || !chip_en);
    logic go;
    logic aux_wr;
    logic rd_ctrl;
    assign aux_wr = host_sel && host_wr && host_addr == ADDR_AUX_SYNTH;
    assign rd_ctrl = host_rd && host_addr == ADDR_CONV_CTRL;
    logic [11:0] busy_cnt_r;
    logic [11:0] busy_cnt_nxt;
    logic [16:0] b_w;
    logic [16:0] a_w;
    assign go = host_cmd_valid && host_cmd == 8'h87;
    assign b_w = {7'h00, aux_synth.b_value};
    assign a_w = {7'h00, aux_synth.a_value};
    always_comb
    begin
        busy_cnt_nxt = adc_busy ? busy_cnt_r + 12'h001 : 12'h000;
        if (go)
        begin
            busy_cnt_nxt = 12'h000;
        end
    end
    always_ff @(posedge mclk)
    begin
        busy_cnt_r <= busy_cnt_nxt;
    end
    sequence s_wr_aux;
        host_sel && host_wr && host_addr == ADDR_AUX_SYNTH;
    endsequence
    sequence s_aux_frame;
        ($rose(host_sel) ##0 s_wr_aux) ##1 s_wr_aux ##1 s_wr_aux;
    endsequence
    property p_aux_frame;
        s_aux_frame |=> aux_synth == {$past(host_wdata, 3), $past(host_wdata, 2),
            $past(host_wdata, 1)};
    endproperty
    AST_AUX_FRAME: assert property (p_aux_frame)
        else $error("aux word differs from its three bytes");
    AST_AUX_HOLD: assert property ($changed(aux_synth) |-> $past(aux_wr))
        else $error("aux word changed without a write");
    AST_DIV_RATIO: assert property (aux_div_ratio == b_w * 17'h20 + a_w * 17'h21)
        else $error("divide ratio wrong");
    AST_DAC_WR: assert property (host_wr && host_addr == ADDR_CONV_CTRL |=> dac_value == $past(host_wdata))
        else $error("control value not stored");
    AST_RXLO_WR: assert property (host_wr && host_addr == ADDR_RXLEN_LO |=> rx_len[7:0] == $past(host_wdata))
        else $error("low length not stored");
    AST_RXHI_WR: assert property (host_wr && host_addr == ADDR_RXLEN_HI |=> rx_len[9:8] == $past(host_wdata[1:0]))
        else $error("high length not stored");
    AST_RXEND: assert property (rx_evt.rx_end && !host_wr |=> rx_len == 10'h000)
        else $error("length not cleared at reception end");
    AST_RD_CTRL: assert property (rd_ctrl |=> host_rvalid && host_rdata == dac_value)
        else $error("control value not read back");
    AST_ADC_GO: assert property (go |=> adc_busy)
        else $error("conversion did not start");
    AST_ADC_IDLE: assert property (!adc_busy && !go |=> !adc_busy)
        else $error("conversion started without command");
    AST_ADC_LIMIT: assert property (adc_busy |-> busy_cnt_r < 12'h7d0)
        else $error("conversion too long");
    AST_CRC_DROP: assert property (rx_byte_valid && rx_byte_is_crc && crc_check_en |=> !fifo_push)
        else $error("checked crc byte pushed");
    AST_SKIP_PUSH: assert property (rx_byte_valid && !crc_check_en |=> fifo_push && fifo_byte == $past(rx_byte))
        else $error("byte not pushed in skipped reception");
endmodule

bind rsr_regs rsr_regs_props u_props (.mclk, .reset_n, .chip_en, .host_sel, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_cmd_valid, .host_cmd, .aux_synth, .aux_div_ratio,
    .dac_value, .adc_busy, .rx_evt, .rx_byte_valid, .rx_byte, .rx_byte_is_crc, .rx_len,
    .crc_check_en, .fifo_push, .fifo_byte, .host_rdata, .host_rvalid);

// ==== bench/rsr_host_model.sv ====
`timescale 1ns/100ps
module rsr_host_model
    import rsr_pkg::*;
(
    // Clock
    mclk,
    // Host port
    host_sel, host_wr, host_rd, host_addr, host_wdata, host_rdata, host_rvalid,
    // Direct commands
    host_cmd_valid, host_cmd
);
    input wire logic mclk;
    output logic host_sel, host_wr, host_rd, host_cmd_valid;
    output logic [4:0] host_addr;
    output logic [7:0] host_wdata, host_cmd;
    input wire logic [7:0] host_rdata;
    input wire logic host_rvalid;
    initial
    begin
        {host_sel, host_wr, host_rd, host_cmd_valid} = 4'h0;
        host_addr = 5'h00;
        host_wdata = 8'h00;
        host_cmd = 8'h00;
    end
    // One frame of n bytes, most significant first; reads wait for the answer.
    task automatic xfer(input logic [4:0] a, input int n, input logic [23:0] wd,
        input logic rd, output logic [23:0] rdw);
        rdw = 24'h000000;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge mclk);
            host_sel = 1'b1;
            host_addr = a;
            host_wr = !rd;
            host_rd = rd;
            host_wdata = wd[8 * i +: 8];
            if (rd)
            begin
                @(negedge mclk);
                host_rd = 1'b0;
                for (int k = 0; k < 4 && host_rvalid !== 1'b1; k++)
                    @(negedge mclk);
                rdw = {rdw[15:0], host_rdata};
            end
        end
        @(negedge mclk);
        {host_sel, host_wr, host_rd} = 3'h0;
        // Released lines must not keep looking valid.
        host_addr = ~host_addr;
        host_wdata = ~host_wdata;
    endtask
    task automatic command(input logic [7:0] code);
        @(negedge mclk);
        host_cmd_valid = 1'b1;
        host_cmd = code;
        @(negedge mclk);
        host_cmd_valid = 1'b0;
        host_cmd = ~code;
    endtask
endmodule

// ==== bench/rsr_regs_tb.sv ====
`timescale 1ns/100ps
module rsr_regs_tb
    import rsr_pkg::*;
;
    logic mclk, reset_n, chip_en, host_sel, host_wr, host_rd, host_rvalid, host_cmd_valid;
    logic adc_busy, rx_byte_valid, rx_byte_is_crc, crc_check_en, fifo_push;
    logic irq_header_line, third_error_irq_line;
    logic [2:0] msel;
    logic [4:0] host_addr;
    logic [7:0] host_wdata, host_rdata, host_cmd, mixer_i_level, mixer_q_level;
    logic [7:0] ext_pin_level, rx_byte, dac_value, fifo_byte;
    logic [9:0] rx_len;
    logic [16:0] aux_div_ratio;
    logic [23:0] w;
    rsr_synth_t aux_synth;
    rsr_rx_evt_t rx_evt;
    int bad_count = 0;
    int samples_checked = 0;
    logic [4:0] zl [5] = '{5'h05, ADDR_CONV_CTRL, ADDR_CONV_READ, ADDR_RXLEN_HI, ADDR_RXLEN_LO};
    logic [23:0] wl [2] = '{24'hb5e2c7, 24'h4a0c3f};
    logic [7:0] lv [3] = '{8'h3c, 8'hc5, 8'h96};
    logic [5:0] ie [4] = '{6'h08, 6'h04, 6'h02, 6'h01};
    logic [1:0] ix [8] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1};
    rsr_regs DUT (.mclk, .reset_n, .chip_en, .host_sel, .host_wr, .host_rd, .host_addr,
        .host_wdata, .host_rdata, .host_rvalid, .host_cmd_valid, .host_cmd, .msel,
        .mixer_i_level, .mixer_q_level, .ext_pin_level, .aux_synth, .aux_div_ratio,
        .dac_value, .adc_busy, .rx_evt, .rx_byte_valid, .rx_byte, .rx_byte_is_crc, .rx_len,
        .crc_check_en, .fifo_push, .fifo_byte, .irq_header_line, .third_error_irq_line);
    rsr_host_model h (.mclk, .host_sel, .host_wr, .host_rd, .host_addr, .host_wdata,
        .host_rdata, .host_rvalid, .host_cmd_valid, .host_cmd);
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        h.xfer(a, 1, {16'h0000, d}, 1'b0, w);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        h.xfer(a, 1, 24'h000000, 1'b1, w);
        chk("register read", w, {16'h0000, e});
    endtask
    task automatic ev(input rsr_rx_evt_t e);
        @(negedge mclk);
        rx_evt = e;
        #1;
    endtask
    task automatic rxb(input logic [7:0] b, input logic crc, input logic push);
        @(negedge mclk);
        rx_byte_valid = 1'b1;
        rx_byte = b;
        rx_byte_is_crc = crc;
        @(negedge mclk);
        rx_byte_valid = 1'b0;
        rx_byte = ~b;
        chk("push", 24'(fifo_push), 24'(push));
        if (push)
            chk("fifo byte", 24'(fifo_byte), 24'(b));
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // About 8200 cycles of work; 30000 cycles, over three and a half times that, before declaring a hang.
    initial
    begin
        #300000;
        bad_count++;
        tally_and_finish;
    end
    initial
    begin
        {reset_n, rx_byte_valid, rx_byte_is_crc} = 3'h0;
        chip_en = 1'b1;
        msel = 3'h0;
        {mixer_i_level, mixer_q_level, ext_pin_level} = {lv[0], lv[1], lv[2]};
        rx_evt = 6'h00;
        rx_byte = 8'h00;
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        chk("aux port", aux_synth, 24'h011846);
        h.xfer(ADDR_AUX_SYNTH, 3, 24'h000000, 1'b1, w);
        chk("aux read", w, 24'h011846);
        foreach (zl[i])
            rdc(zl[i], 8'h00);
        h.xfer(ADDR_AUX_SYNTH, 2, 24'h00abcd, 1'b0, w);
        chk("aux partial", aux_synth, 24'h011846);
        foreach (wl[i])
        begin
            h.xfer(ADDR_AUX_SYNTH, 3, wl[i], 1'b0, w);
            chk("aux word", aux_synth, wl[i]);
            chk("ratio", 24'(aux_div_ratio), 24'({7'h00, wl[i][19:10]} * 17'h20
                + {7'h00, wl[i][9:0]} * 17'h21));
            h.xfer(ADDR_AUX_SYNTH, 3, 24'h000000, 1'b1, w);
            chk("aux back", w, wl[i]);
        end
        wr8(ADDR_CONV_CTRL, 8'h5a);
        chk("dac", 24'(dac_value), 24'h00005a);
        rdc(ADDR_CONV_CTRL, 8'h5a);
        for (int m = 0; m < 4; m++)
        begin
            msel = 3'(m);
            h.command(8'h80);
            chk("busy idle", 24'(adc_busy), 24'h0);
            h.command(8'h87);
            repeat (1990) @(negedge mclk);
            chk("busy held", 24'(adc_busy), 24'h1);
            for (int k = 0; k < 10 && adc_busy === 1'b1; k++)
                @(negedge mclk);
            chk("busy done", 24'(adc_busy), 24'h0);
            rdc(ADDR_CONV_READ, lv[(m == 3) ? 0 : m]);
        end
        wr8(ADDR_CONV_READ, 8'hff);
        rdc(ADDR_CONV_READ, lv[0]);
        wr8(ADDR_RXLEN_HI, 8'hbe);
        wr8(ADDR_RXLEN_LO, 8'h5c);
        chk("rx len", 24'(rx_len), 24'h00025c);
        rdc(ADDR_RXLEN_HI, 8'h82);
        ev(6'h20);
        ev(6'h00);
        chk("crc off", 24'(crc_check_en), 24'h0);
        rxb(8'h11, 1'b0, 1'b1);
        rxb(8'ha7, 1'b1, 1'b1);
        ev(6'h10);
        ev(6'h00);
        chk("len clear", 24'(rx_len), 24'h0);
        rdc(ADDR_RXLEN_HI, 8'h00);
        ev(6'h20);
        ev(6'h00);
        chk("crc on", 24'(crc_check_en), 24'h1);
        rxb(8'h6e, 1'b1, 1'b0);
        ev(6'h10);
        for (int o = 0; o < 2; o++)
        begin
            wr8(ADDR_RXLEN_HI, o ? 8'h40 : 8'h00);
            foreach (ie[i])
            begin
                ev(ie[i]);
                chk("irq", 24'({irq_header_line, third_error_irq_line}), 24'(ix[o * 4 + i]));
            end
            ev(6'h00);
        end
        wr8(ADDR_RXLEN_LO, 8'h33);
        chip_en = 1'b0;
        repeat (6) @(negedge mclk);
        chip_en = 1'b1;
        repeat (4) @(negedge mclk);
        chk("aux after off", aux_synth, 24'h011846);
        foreach (zl[i])
            rdc(zl[i], 8'h00);
        tally_and_finish;
    end
endmodule
